//--- rtl/itrf_pkg.sv
// Shared constants and types for the IPv4 transmit request framer link
package itrf_pkg;
	// Frame framing
	localparam logic [7:0] START_DELIM = 8'h7e;
	localparam logic [7:0] TYPE_TX_IPV4 = 8'h20;
	localparam logic [7:0] TYPE_SEND_DATA = 8'h28;
	localparam logic [7:0] CSUM_BASE = 8'hff;
	// Byte offsets inside a frame
	localparam logic [15:0] OFS_TYPE = 16'h0003;
	localparam logic [15:0] OFS_FID = 16'h0004;
	localparam logic [15:0] OFS_DST_MSB = 16'h0005;
	localparam logic [15:0] OFS_DST_LSB = 16'h0008;
	localparam logic [15:0] OFS_DPORT_HI = 16'h0009;
	localparam logic [15:0] OFS_DPORT_LO = 16'h000a;
	localparam logic [15:0] OFS_SPORT_HI = 16'h000b;
	localparam logic [15:0] OFS_SPORT_LO = 16'h000c;
	localparam logic [15:0] OFS_PROTO = 16'h000d;
	localparam logic [15:0] OFS_OPT = 16'h000e;
	localparam logic [15:0] OFS_PAYLOAD = 16'h000f;
	localparam logic [15:0] OFS_PATH_LEN = 16'h0005;
	localparam logic [15:0] OFS_PATH = 16'h0006;
	// Fixed byte counts covered by the length field
	localparam logic [15:0] TX_HDR_LEN = 16'h000c;
	localparam logic [15:0] SEND_FIX_LEN = 16'h0006;
	// Send-data fixed field steps
	localparam logic [3:0] SD_TYPE = 4'h0;
	localparam logic [3:0] SD_FID = 4'h1;
	localparam logic [3:0] SD_PLEN = 4'h2;
	localparam logic [3:0] SD_CLEN = 4'h3;
	localparam logic [3:0] SD_TRANS = 4'h4;
	localparam logic [3:0] SD_OPT = 4'h5;
	// Limits
	localparam logic [10:0] MAX_PAYLOAD_QUERY = 11'h570;
	localparam logic [10:0] PAYLOAD_GAP = 11'h008;
	localparam logic [10:0] PAYLOAD_MAX = MAX_PAYLOAD_QUERY + PAYLOAD_GAP;
	localparam logic [7:0] CTYPE_MAX = 8'h10;
	// Encodings
	localparam logic [7:0] PROTO_UDP = 8'h00;
	localparam logic [7:0] PROTO_TCP = 8'h01;
	localparam logic [7:0] TRANSPORT_TCP = 8'h00;
	localparam int OPT_CLOSE_BIT = 1;
	localparam logic [7:0] OPT_KEEP_MASK = 8'h02;
	localparam logic [31:0] BCAST_ADDR = 32'hffffffff;
	typedef enum logic [1:0] {
		STORE_OVERWRITE = 2'b00,
		STORE_ARCHIVE = 2'b01,
		STORE_APPEND = 2'b10,
		STORE_TRANSIENT = 2'b11
	} itrf_store_t;
	typedef enum logic [1:0] {
		SEG_DATA = 2'b00,
		SEG_PATH = 2'b01,
		SEG_CTYPE = 2'b10
	} itrf_seg_t;
	// Host register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FRAME_ID = 8'h08;
	localparam logic [7:0] REG_DEST_ADDR = 8'h0c;
	localparam logic [7:0] REG_PORTS = 8'h10;
	localparam logic [7:0] REG_OPTIONS = 8'h14;
	localparam logic [7:0] REG_LISTEN = 8'h18;
	localparam logic [7:0] REG_LENGTHS = 8'h1c;
	localparam logic [7:0] REG_DATA = 8'h20;
	// Register field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_KIND = 1;
	localparam int CTRL_BCAST = 2;
	localparam int CTRL_NEWCONN = 3;
	localparam int CTRL_CLRPTR = 4;
	localparam int CTRL_CLRERR = 5;
	localparam int STAT_BUSY = 0;
	localparam int STAT_REJECT = 1;
	localparam int OPTR_PROTO_LSB = 0;
	localparam int OPTR_TXOPT_LSB = 8;
	localparam int OPTR_STORE_LSB = 16;
	localparam int LEN_PATH_LSB = 0;
	localparam int LEN_CTYPE_LSB = 8;
	localparam int LEN_DATA_LSB = 16;
	localparam int PORT_DST_LSB = 16;
endpackage

//--- rtl/itrf_link_if.sv
// Byte stream link between the host framer and the device parser
`timescale 1ns/1ps
interface itrf_link_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	modport host (output data, output valid, input ready);
	modport dev (input data, input valid, output ready);
endinterface

//--- rtl/itrf_host.sv
// Host end: Wishbone-controlled builder of transmit and send-data frames
//
// Behaviour
// - Frame id byte; zero suppresses status
// - UDP broadcast uses all-ones destination
// - Destination address offsets 5-8, MSB first
// - Destination port offsets 9-10, high first
// - UDP source port equals listening port
// - New TCP connection sends source port zero
// - Protocol byte: 0 UDP, 1 TCP
// - Option bit 1 closes TCP socket
// - Reserved option bits sent as zero
// - Payload at 15, at most 1400
// - Limit is reported maximum plus eight
// - Type 0x28 requests file upload
// - Zero id means no send-data status
// - Path length byte precedes path string
// - Content type length at most 16
// - Send-data transport byte is zero
// - Storage action: overwrite/archive/append/transient
`timescale 1ns/1ps
module itrf_host #(
	parameter int MEM_AW = 11
) (
	// System
	input wire logic CLK_I,
	input wire logic RESET_I,
	// Wishbone slave
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	input wire logic WE_I,
	input wire logic [3:0] SEL_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	output logic ACK_O,
	// Link
	itrf_link_if.host LINK
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_SOF = 3'b001,
		H_LENH = 3'b010,
		H_LENL = 3'b011,
		H_FIX = 3'b100,
		H_BODY = 3'b101,
		H_CSUM = 3'b110
	} itrf_hstate_t;

	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic ack;
	logic [31:0] rdata;
	logic kind, bcast, newconn, err;
	logic [7:0] fid, txopt, proto, plen, clen;
	logic [31:0] dst;
	logic [15:0] dport, sport, listen;
	logic [1:0] store;
	logic [10:0] dlen;
	logic [7:0] mem [0:(1<<MEM_AW)-1];
	logic [MEM_AW-1:0] wptr, rptr;
	itrf_hstate_t state;
	logic [3:0] step;
	logic [10:0] cnt;
	logic [7:0] sum;
	logic [15:0] flen;
	logic [7:0] out_data;
	logic out_valid;

	// Bus decode
	wire acc = CYC_I & STB_I & ~ack;
	wire wr = acc & WE_I;
	logic [31:0] rd_mux;
	wire [31:0] wword = lane_merge(rd_mux, DAT_I, SEL_I);
	wire ctrl_wr = wr & (ADR_I == itrf_pkg::REG_CTRL);
	// Kind written with START is not yet in the register at the start edge
	wire kind_new = wword[itrf_pkg::CTRL_KIND];
	wire busy = (state != H_IDLE) | out_valid;
	wire start = ctrl_wr & wword[itrf_pkg::CTRL_START] & ~busy;
	wire too_long = (dlen > itrf_pkg::PAYLOAD_MAX) |
		(kind_new & (clen > itrf_pkg::CTYPE_MAX));
	wire go = start & ~too_long;
	wire clr_err = ctrl_wr & wword[itrf_pkg::CTRL_CLRERR];
	wire data_wr = wr & (ADR_I == itrf_pkg::REG_DATA) & SEL_I[0];

	always_comb begin
		rd_mux = '0;
		case (ADR_I)
			itrf_pkg::REG_CTRL: begin
				rd_mux[itrf_pkg::CTRL_KIND] = kind;
				rd_mux[itrf_pkg::CTRL_BCAST] = bcast;
				rd_mux[itrf_pkg::CTRL_NEWCONN] = newconn;
			end
			itrf_pkg::REG_STATUS: begin
				rd_mux[itrf_pkg::STAT_BUSY] = busy;
				rd_mux[itrf_pkg::STAT_REJECT] = err;
			end
			itrf_pkg::REG_FRAME_ID: rd_mux[7:0] = fid;
			itrf_pkg::REG_DEST_ADDR: rd_mux = dst;
			itrf_pkg::REG_PORTS: rd_mux = {dport, sport};
			itrf_pkg::REG_OPTIONS: begin
				rd_mux[itrf_pkg::OPTR_PROTO_LSB +: 8] = proto;
				rd_mux[itrf_pkg::OPTR_TXOPT_LSB +: 8] = txopt;
				rd_mux[itrf_pkg::OPTR_STORE_LSB +: 2] = store;
			end
			itrf_pkg::REG_LISTEN: rd_mux[15:0] = listen;
			itrf_pkg::REG_LENGTHS: begin
				rd_mux[itrf_pkg::LEN_PATH_LSB +: 8] = plen;
				rd_mux[itrf_pkg::LEN_CTYPE_LSB +: 8] = clen;
				rd_mux[itrf_pkg::LEN_DATA_LSB +: 11] = dlen;
			end
			itrf_pkg::REG_DATA: rd_mux[MEM_AW-1:0] = wptr;
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			ack <= 1'b0;
			rdata <= '0;
		end else begin
			ack <= acc;
			if (acc) begin
				rdata <= rd_mux;
			end
		end
	end

	// Software registers; writes mid-frame change the frame in flight
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			{kind, bcast, newconn} <= '0;
			fid <= '0;
			dst <= '0;
			{dport, sport} <= '0;
			{proto, txopt, store} <= '0;
			listen <= '0;
			{plen, clen, dlen} <= '0;
		end else if (wr) begin
			case (ADR_I)
				itrf_pkg::REG_CTRL: begin
					kind <= wword[itrf_pkg::CTRL_KIND];
					bcast <= wword[itrf_pkg::CTRL_BCAST];
					newconn <= wword[itrf_pkg::CTRL_NEWCONN];
				end
				itrf_pkg::REG_FRAME_ID: fid <= wword[7:0];
				itrf_pkg::REG_DEST_ADDR: dst <= wword;
				itrf_pkg::REG_PORTS: {dport, sport} <= wword;
				itrf_pkg::REG_OPTIONS: begin
					proto <= wword[itrf_pkg::OPTR_PROTO_LSB +: 8];
					txopt <= wword[itrf_pkg::OPTR_TXOPT_LSB +: 8];
					store <= wword[itrf_pkg::OPTR_STORE_LSB +: 2];
				end
				itrf_pkg::REG_LISTEN: listen <= wword[15:0];
				itrf_pkg::REG_LENGTHS: begin
					plen <= wword[itrf_pkg::LEN_PATH_LSB +: 8];
					clen <= wword[itrf_pkg::LEN_CTYPE_LSB +: 8];
					dlen <= wword[itrf_pkg::LEN_DATA_LSB +: 11];
				end
				default: ;
			endcase
		end
	end

	// Reject flag: a refusal in the clearing cycle still shows
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			err <= 1'b0;
			wptr <= '0;
		end else begin
			err <= (start & too_long) | (err & ~clr_err);
			if (ctrl_wr & wword[itrf_pkg::CTRL_CLRPTR]) begin
				wptr <= '0;
			end else if (data_wr) begin
				wptr <= wptr + 1'b1;
			end
		end
	end

	// Body store: path, content type and data, back to back
	always_ff @(posedge CLK_I) begin
		if (data_wr) begin
			mem[wptr] <= DAT_I[7:0];
		end
	end

	// Field values
	wire udp = (proto == itrf_pkg::PROTO_UDP);
	wire [31:0] dst_eff = (udp & bcast) ? itrf_pkg::BCAST_ADDR : dst;
	wire [15:0] src_eff = udp ? listen : (newconn ? 16'h0000 : sport);
	wire [15:0] off = itrf_pkg::OFS_TYPE + {12'h000, step};
	logic [7:0] fix_byte, gen_byte;
	logic [10:0] seg_len;
	logic body_next, final_seg;

	always_comb begin
		fix_byte = 8'h00;
		if (!kind) begin
			case (off)
				itrf_pkg::OFS_TYPE: fix_byte = itrf_pkg::TYPE_TX_IPV4;
				itrf_pkg::OFS_FID: fix_byte = fid;
				itrf_pkg::OFS_DST_MSB: fix_byte = dst_eff[31:24];
				itrf_pkg::OFS_DST_MSB + 16'h0001: fix_byte = dst_eff[23:16];
				itrf_pkg::OFS_DST_MSB + 16'h0002: fix_byte = dst_eff[15:8];
				itrf_pkg::OFS_DST_LSB: fix_byte = dst_eff[7:0];
				itrf_pkg::OFS_DPORT_HI: fix_byte = dport[15:8];
				itrf_pkg::OFS_DPORT_LO: fix_byte = dport[7:0];
				itrf_pkg::OFS_SPORT_HI: fix_byte = src_eff[15:8];
				itrf_pkg::OFS_SPORT_LO: fix_byte = src_eff[7:0];
				itrf_pkg::OFS_PROTO: fix_byte = proto;
				itrf_pkg::OFS_OPT: fix_byte = txopt & itrf_pkg::OPT_KEEP_MASK;
				default: fix_byte = 8'h00;
			endcase
		end else begin
			case (step)
				itrf_pkg::SD_TYPE: fix_byte = itrf_pkg::TYPE_SEND_DATA;
				itrf_pkg::SD_FID: fix_byte = fid;
				itrf_pkg::SD_PLEN: fix_byte = plen;
				itrf_pkg::SD_CLEN: fix_byte = clen;
				itrf_pkg::SD_TRANS: fix_byte = itrf_pkg::TRANSPORT_TCP;
				itrf_pkg::SD_OPT: fix_byte = {6'h00, store};
				default: fix_byte = 8'h00;
			endcase
		end
	end

	assign body_next = kind ? (step == itrf_pkg::SD_PLEN) | (step == itrf_pkg::SD_CLEN) |
		(step == itrf_pkg::SD_OPT) : (off == itrf_pkg::OFS_OPT);
	assign final_seg = ~kind | (step == itrf_pkg::SD_OPT);
	assign seg_len = (kind & (step == itrf_pkg::SD_PLEN)) ? {3'h0, plen} :
		(kind & (step == itrf_pkg::SD_CLEN)) ? {3'h0, clen} : dlen;

	always_comb begin
		case (state)
			H_SOF: gen_byte = itrf_pkg::START_DELIM;
			H_LENH: gen_byte = flen[15:8];
			H_LENL: gen_byte = flen[7:0];
			H_FIX: gen_byte = fix_byte;
			H_BODY: gen_byte = mem[rptr];
			H_CSUM: gen_byte = itrf_pkg::CSUM_BASE - sum;
			default: gen_byte = 8'h00;
		endcase
	end

	wire adv = (state != H_IDLE) & (~out_valid | LINK.ready);
	wire [15:0] len_send = itrf_pkg::SEND_FIX_LEN + {8'h00, plen} + {8'h00, clen} + {5'h00, dlen};
	wire [15:0] len_tx = itrf_pkg::TX_HDR_LEN + {5'h00, dlen};

	// Frame sequencer; the link byte is registered and held until taken
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			state <= H_IDLE;
			step <= '0;
			cnt <= '0;
			rptr <= '0;
			sum <= '0;
			flen <= '0;
			out_data <= '0;
			out_valid <= 1'b0;
		end else begin
			if (adv) begin
				out_data <= gen_byte;
				out_valid <= 1'b1;
			end else if (LINK.ready) begin
				out_valid <= 1'b0;
			end
			if (go) begin
				state <= H_SOF;
				flen <= kind_new ? len_send : len_tx;
				step <= '0;
				rptr <= '0;
				sum <= '0;
			end else if (adv) begin
				case (state)
					H_SOF: state <= H_LENH;
					H_LENH: state <= H_LENL;
					H_LENL: state <= H_FIX;
					H_FIX: begin
						sum <= sum + gen_byte;
						if (body_next && seg_len != 11'h000) begin
							state <= H_BODY;
							cnt <= seg_len;
						end else if (body_next && final_seg) begin
							state <= H_CSUM;
						end else begin
							step <= step + 4'h1;
						end
					end
					H_BODY: begin
						sum <= sum + gen_byte;
						rptr <= rptr + 1'b1;
						cnt <= cnt - 11'h001;
						if (cnt == 11'h001) begin
							state <= final_seg ? H_CSUM : H_FIX;
							step <= step + 4'h1;
						end
					end
					H_CSUM: state <= H_IDLE;
					default: state <= H_IDLE;
				endcase
			end
		end
	end

	assign LINK.data = out_data;
	assign LINK.valid = out_valid;
	assign DAT_O = rdata;
	assign ACK_O = ack;
endmodule

//--- rtl/itrf_dev.sv
// Device end: parser of transmit and send-data frames with a small output buffer
`timescale 1ns/1ps
module itrf_dev #(
	parameter int BUF_DEPTH = 2
) (
	// System
	input wire logic CLK_I,
	input wire logic RESET_I,
	// Link
	itrf_link_if.dev LINK,
	// Byte stream out
	output logic [7:0] PLD_DATA_O,
	output logic [1:0] PLD_SEG_O,
	output logic PLD_VALID_O,
	input wire logic PLD_READY_I,
	// Frame results
	output logic FRAME_DONE_O,
	output logic FRAME_GOOD_O,
	output logic STATUS_WANTED_O,
	output logic CLOSE_SOCKET_O,
	output logic TRUNCATED_O,
	output logic [7:0] FRAME_TYPE_O,
	output logic [7:0] FRAME_ID_O,
	output logic [31:0] DEST_ADDR_O,
	output logic [15:0] DEST_PORT_O,
	output logic [15:0] SRC_PORT_O,
	output logic [7:0] PROTO_O,
	output logic [7:0] TX_OPT_O,
	output logic [7:0] PATH_LEN_O,
	output logic [7:0] CTYPE_LEN_O,
	output logic [7:0] TRANSPORT_O,
	output logic [1:0] STORE_ACTION_O
);
	typedef enum logic [2:0] {
		D_SOF = 3'b000,
		D_LENH = 3'b001,
		D_LENL = 3'b010,
		D_BODY = 3'b011,
		D_CSUM = 3'b100
	} itrf_dstate_t;
	localparam int PW = $clog2(BUF_DEPTH);

	itrf_dstate_t state;
	logic [7:0] lenh, sum, typ, fid, proto, opt, plen, clen, trans;
	logic [15:0] rem, off, dport, sport;
	logic [31:0] dst;
	logic [1:0] store;
	logic [10:0] dcnt;
	logic [7:0] ccnt;
	logic done, good, wanted, close, trunc;
	// Power-of-two depth only: pointers wrap by overflow
	logic [9:0] buf_mem [0:BUF_DEPTH-1];
	logic [PW-1:0] wp, rp;
	logic [PW:0] level;

	wire [7:0] b = LINK.data;
	wire take = LINK.valid & LINK.ready;
	wire in_body = (state == D_BODY);
	wire is_tx = (typ == itrf_pkg::TYPE_TX_IPV4);
	wire is_sd = (typ == itrf_pkg::TYPE_SEND_DATA);
	wire [15:0] p_end = itrf_pkg::OFS_PATH + {8'h00, plen};
	wire [15:0] c_beg = p_end + 16'h0001;
	wire [15:0] t_off = c_beg + {8'h00, clen};
	wire [15:0] o_off = t_off + 16'h0001;
	wire [15:0] d_beg = o_off + 16'h0001;
	wire seg_path = is_sd & (off >= itrf_pkg::OFS_PATH) & (off < p_end);
	wire seg_ct = is_sd & (off >= c_beg) & (off < t_off);
	wire seg_data = is_tx ? (off >= itrf_pkg::OFS_PAYLOAD) : (is_sd & (off >= d_beg));
	wire data_room = dcnt < itrf_pkg::PAYLOAD_MAX;
	wire ct_room = ccnt < itrf_pkg::CTYPE_MAX;
	wire emit = in_body & (seg_data ? data_room : (seg_ct ? ct_room : seg_path));
	wire buf_in_ready = (level != BUF_DEPTH[PW:0]);
	wire push = take & emit;
	wire pop = PLD_VALID_O & PLD_READY_I;
	wire [1:0] seg = seg_data ? itrf_pkg::SEG_DATA : (seg_ct ? itrf_pkg::SEG_CTYPE :
		itrf_pkg::SEG_PATH);
	wire dropped = take & in_body & ((seg_data & ~data_room) | (seg_ct & ~ct_room));
	wire csum_ok = (itrf_pkg::CSUM_BASE - sum) == b;

	// Stall the link only for a byte that needs buffer room
	assign LINK.ready = ~emit | buf_in_ready;

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			state <= D_SOF;
			{lenh, sum, typ, fid, proto, opt, plen, clen, trans} <= '0;
			{rem, off, dport, sport, dst, store, dcnt, ccnt} <= '0;
			{done, good, wanted, close, trunc} <= '0;
		end else begin
			done <= 1'b0;
			if (take) begin
				case (state)
					D_SOF: begin
						if (b == itrf_pkg::START_DELIM) begin
							state <= D_LENH;
						end
					end
					D_LENH: begin
						lenh <= b;
						state <= D_LENL;
					end
					D_LENL: begin
						rem <= {lenh, b};
						off <= itrf_pkg::OFS_TYPE;
						sum <= '0;
						typ <= '0;
						dcnt <= '0;
						ccnt <= '0;
						trunc <= 1'b0;
						state <= ({lenh, b} == 16'h0000) ? D_CSUM : D_BODY;
					end
					D_BODY: begin
						sum <= sum + b;
						off <= off + 16'h0001;
						rem <= rem - 16'h0001;
						if (rem == 16'h0001) begin
							state <= D_CSUM;
						end
						if (off == itrf_pkg::OFS_TYPE) begin
							typ <= b;
						end
						if (off == itrf_pkg::OFS_FID) begin
							fid <= b;
						end
						if (is_tx) begin
							if (off >= itrf_pkg::OFS_DST_MSB && off <= itrf_pkg::OFS_DST_LSB) begin
								dst <= {dst[23:0], b};
							end
							if (off == itrf_pkg::OFS_DPORT_HI) begin
								dport[15:8] <= b;
							end
							if (off == itrf_pkg::OFS_DPORT_LO) begin
								dport[7:0] <= b;
							end
							if (off == itrf_pkg::OFS_SPORT_HI) begin
								sport[15:8] <= b;
							end
							if (off == itrf_pkg::OFS_SPORT_LO) begin
								sport[7:0] <= b;
							end
							if (off == itrf_pkg::OFS_PROTO) begin
								proto <= b;
							end
							if (off == itrf_pkg::OFS_OPT) begin
								opt <= b;
							end
						end
						if (is_sd) begin
							if (off == itrf_pkg::OFS_PATH_LEN) begin
								plen <= b;
							end
							if (off == p_end) begin
								clen <= b;
							end
							if (off == t_off) begin
								trans <= b;
							end
							if (off == o_off) begin
								store <= b[1:0];
							end
						end
						if (seg_data && data_room) begin
							dcnt <= dcnt + 11'h001;
						end
						if (seg_ct && ct_room) begin
							ccnt <= ccnt + 8'h01;
						end
						if (dropped) begin
							trunc <= 1'b1;
						end
					end
					D_CSUM: begin
						done <= 1'b1;
						good <= csum_ok;
						wanted <= csum_ok & (fid != 8'h00);
						close <= csum_ok & is_tx & (proto == itrf_pkg::PROTO_TCP) &
							opt[itrf_pkg::OPT_CLOSE_BIT];
						state <= D_SOF;
					end
					default: state <= D_SOF;
				endcase
			end
		end
	end

	// Bytes leave before the checksum is known; consumers must drop bad frames
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			wp <= '0;
			rp <= '0;
			level <= '0;
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
			level <= level + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		end
	end

	always_ff @(posedge CLK_I) begin
		if (push) begin
			buf_mem[wp] <= {seg, b};
		end
	end

	assign PLD_VALID_O = (level != '0);
	assign {PLD_SEG_O, PLD_DATA_O} = PLD_VALID_O ? buf_mem[rp] : 10'h000;
	assign FRAME_DONE_O = done;
	assign FRAME_GOOD_O = good;
	assign STATUS_WANTED_O = wanted;
	assign CLOSE_SOCKET_O = close;
	assign TRUNCATED_O = trunc;
	assign FRAME_TYPE_O = typ;
	assign FRAME_ID_O = fid;
	assign DEST_ADDR_O = dst;
	assign DEST_PORT_O = dport;
	assign SRC_PORT_O = sport;
	assign PROTO_O = proto;
	assign TX_OPT_O = opt;
	assign PATH_LEN_O = plen;
	assign CTYPE_LEN_O = clen;
	assign TRANSPORT_O = trans;
	assign STORE_ACTION_O = store;
endmodule

//--- test/itrf_link_chk.sv
// Checker on the byte link between host framer and device parser
`timescale 1ns/1ps
module itrf_link_chk (
	// System
	input wire logic CLK_I,
	input wire logic RESET_I,
	// Link
	input wire logic [7:0] data,
	input wire logic valid,
	input wire logic ready
);
	logic [15:0] pos;
	logic [15:0] len;
	logic [7:0] sum;
	logic [7:0] typ;
	wire take = valid & ready;
	// Checksum sits right after the last body byte
	wire last = (pos > 16'h0003) && (pos == len + 16'h0003);
	wire [15:0] next_pos = last ? 16'h0000 : pos + 16'h0001;
	wire [7:0] next_sum = (pos < 16'h0003) ? 8'h00 : sum + data;

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			pos <= 16'h0000;
			sum <= 8'h00;
		end else if (take) begin
			pos <= next_pos;
			sum <= next_sum;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			len <= 16'h0000;
			typ <= 8'h00;
		end else if (take) begin
			if (pos == 16'h0001) len[15:8] <= data;
			if (pos == 16'h0002) len[7:0] <= data;
			if (pos == 16'h0003) typ <= data;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	sequence s_stall;
		valid && !ready;
	endsequence
	sequence s_held;
		valid && $stable(data);
	endsequence
	sequence s_type_byte;
		take && pos == 16'h0003;
	endsequence

	a_valid_hold: assert property (s_stall |=> s_held)
		else $error("link byte changed before it was taken");
	a_start_delim: assert property (take && pos == 16'h0000 |-> data == 8'h7e)
		else $error("frame does not open with the delimiter");
	a_frame_type: assert property (s_type_byte |-> data == 8'h20 || data == 8'h28)
		else $error("unexpected frame type byte");
	a_csum_byte: assert property (take && last |-> data == 8'hff - sum)
		else $error("checksum byte wrong");
	a_proto_code: assert property (take && pos == 16'h000d && typ == 8'h20 |-> data <= 8'h01)
		else $error("protocol byte out of range");
	a_opt_reserved: assert property (take && pos == 16'h000e && typ == 8'h20
		|-> (data & 8'hfd) == 8'h00)
		else $error("reserved option bits set");
	a_payload_cap: assert property ((s_type_byte and (data == 8'h20))
		|-> len >= 16'h000c && len <= 16'h0584)
		else $error("transmit frame length out of range");
	a_send_len: assert property ((s_type_byte and (data == 8'h28)) |-> len >= 16'h0006)
		else $error("send-data frame too short");
endmodule

//--- test/testbench.sv
// Bench driving the host over Wishbone and watching the device outputs
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic pld_ready = 1'b1;
	logic ack, pld_valid, done, good, stat_w, close_s, trunc;
	logic [31:0] rdat, rd, daddr;
	logic [7:0] pld_data, ftype, fid, proto, txopt, plen, clen, trans;
	logic [1:0] pld_seg, store;
	logic [15:0] dport, sport;
	logic [9:0] got_q[$];
	int n_errors = 0;
	int compares = 0;

	always #5 clk = ~clk;

	itrf_link_if link();
	itrf_host itrf_host_inst (.CLK_I(clk), .RESET_I(rst), .ADR_I(adr), .DAT_I(wdat),
		.DAT_O(rdat), .WE_I(we), .SEL_I(4'hf), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
		.LINK(link.host));
	itrf_dev itrf_dev_inst (.CLK_I(clk), .RESET_I(rst), .LINK(link.dev),
		.PLD_DATA_O(pld_data), .PLD_SEG_O(pld_seg), .PLD_VALID_O(pld_valid),
		.PLD_READY_I(pld_ready), .FRAME_DONE_O(done), .FRAME_GOOD_O(good),
		.STATUS_WANTED_O(stat_w), .CLOSE_SOCKET_O(close_s), .TRUNCATED_O(trunc),
		.FRAME_TYPE_O(ftype), .FRAME_ID_O(fid), .DEST_ADDR_O(daddr), .DEST_PORT_O(dport),
		.SRC_PORT_O(sport), .PROTO_O(proto), .TX_OPT_O(txopt), .PATH_LEN_O(plen),
		.CTYPE_LEN_O(clen), .TRANSPORT_O(trans), .STORE_ACTION_O(store));
	itrf_link_chk itrf_link_chk_inst (.CLK_I(clk), .RESET_I(rst), .data(link.data),
		.valid(link.valid), .ready(link.ready));

	// Pre-edge values, so this sees what the buffer handed over at the edge
	always @(posedge clk) if (pld_valid === 1'b1 && pld_ready === 1'b1)
		got_q.push_back({pld_seg, pld_data});

	task final_report();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wb(input logic [7:0] a, input logic [31:0] d, input logic w);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wdat <= d;
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = rdat;
		if (n >= 50) chk(32'h0, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task setup(input logic [7:0] id, input logic [31:0] dst, input logic [31:0] ports,
		input logic [31:0] opts, input logic [31:0] lens, input string body);
		wb(itrf_pkg::REG_FRAME_ID, {24'h0, id}, 1'b1);
		wb(itrf_pkg::REG_DEST_ADDR, dst, 1'b1);
		wb(itrf_pkg::REG_PORTS, ports, 1'b1);
		wb(itrf_pkg::REG_OPTIONS, opts, 1'b1);
		wb(itrf_pkg::REG_LENGTHS, lens, 1'b1);
		wb(itrf_pkg::REG_CTRL, 32'h10, 1'b1);
		for (int i = 0; i < body.len(); i++) begin
			wb(itrf_pkg::REG_DATA, {24'h0, body[i]}, 1'b1);
		end
	endtask

	task frame(input logic [31:0] ctrl);
		int n;
		n = 0;
		got_q.delete();
		wb(itrf_pkg::REG_CTRL, ctrl | 32'h1, 1'b1);
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 5000);
		if (n >= 5000) chk(32'h0, 32'h2);
		// Buffer may still hold bytes when the frame completes
		repeat (4) @(negedge clk);
	endtask

	task chk_str(input string s, input logic [1:0] sg);
		for (int i = 0; i < s.len(); i++) begin
			chk(got_q.size() > 0 ? got_q.pop_front() : 10'h3ff, {sg, s[i]});
		end
	endtask

	initial begin
		// About three times the longest expected run
		#200000;
		n_errors++;
		$display("ERROR %0t: watchdog expired", $time);
		final_report();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		wb(itrf_pkg::REG_STATUS, 32'h0, 1'b0);
		chk(rd, 32'h0);
		wb(8'h40, 32'h5a, 1'b1);
		wb(8'h40, 32'h0, 1'b0);
		chk(rd, 32'h0);
		wb(itrf_pkg::REG_LISTEN, 32'h2616, 1'b1);
		// UDP frame while the consumer stalls
		setup(8'h01, 32'hc0a80064, 32'h26161234, 32'h0, 32'h00050000, "Hello");
		pld_ready <= 1'b0;
		fork
			frame(32'h0);
			begin
				repeat (60) @(negedge clk);
				chk(link.ready, 32'h0);
				chk(pld_valid, 32'h1);
				@(posedge clk);
				pld_ready <= 1'b1;
			end
		join
		chk(ftype, 32'h20);
		chk(fid, 32'h01);
		chk(stat_w, 32'h1);
		chk(daddr, 32'hc0a80064);
		chk(dport, 32'h2616);
		chk(sport, 32'h2616);
		chk(proto, 32'h0);
		chk(good, 32'h1);
		chk_str("Hello", 2'h0);
		// TCP on a new connection, closing afterwards
		setup(8'h00, 32'h0a000001, 32'h00501111, 32'h0000ff01, 32'h00010000, "Z");
		frame(32'h8);
		chk(stat_w, 32'h0);
		chk(sport, 32'h0);
		chk(dport, 32'h0050);
		chk(proto, 32'h1);
		chk(txopt, 32'h02);
		chk(close_s, 32'h1);
		// UDP broadcast; close bit has no effect
		setup(8'h07, 32'h01020304, 32'h00070008, 32'h00000200, 32'h00010000, "Q");
		frame(32'h4);
		chk(daddr, 32'hffffffff);
		chk(close_s, 32'h0);
		chk(sport, 32'h2616);
		for (int k = 0; k < 4; k++) begin
			setup(k == 0 ? 8'h00 : 8'h55, 32'h0, 32'h0, {14'h0, k[1:0], 16'h0},
				32'h00010203, "a/btxz");
			frame(32'h2);
			chk(ftype, 32'h28);
			chk(stat_w, {31'h0, k != 0});
			chk(plen, 32'h3);
			chk(clen, 32'h2);
			chk(trans, 32'h0);
			chk(store, {30'h0, k[1:0]});
			chk(good, 32'h1);
			chk_str("a/b", 2'h1);
			chk_str("tx", 2'h2);
			chk_str("z", 2'h0);
		end
		// Oversize requests are refused and flagged
		setup(8'h09, 32'h0, 32'h0, 32'h0, 32'h05790000, "");
		wb(itrf_pkg::REG_CTRL, 32'h1, 1'b1);
		wb(itrf_pkg::REG_STATUS, 32'h0, 1'b0);
		chk(rd, 32'h2);
		wb(itrf_pkg::REG_CTRL, 32'h20, 1'b1);
		wb(itrf_pkg::REG_LENGTHS, 32'h00001100, 1'b1);
		wb(itrf_pkg::REG_CTRL, 32'h3, 1'b1);
		wb(itrf_pkg::REG_STATUS, 32'h0, 1'b0);
		chk(rd, 32'h2);
		wb(itrf_pkg::REG_CTRL, 32'h20, 1'b1);
		wb(itrf_pkg::REG_STATUS, 32'h0, 1'b0);
		chk(rd, 32'h0);
		// Largest payload goes through whole
		wb(itrf_pkg::REG_LENGTHS, 32'h05780000, 1'b1);
		wb(itrf_pkg::REG_CTRL, 32'h10, 1'b1);
		for (int i = 0; i < 1400; i++) wb(itrf_pkg::REG_DATA, {24'h0, i[7:0]}, 1'b1);
		frame(32'h0);
		chk(good, 32'h1);
		chk(trunc, 32'h0);
		chk(got_q.size(), 32'd1400);
		chk(got_q[1399], 32'h077);
		final_report();
	end
endmodule
